/* File: ebarb_pkg.sv */
// Shared constants and types for the external bus arbitration block.
package ebarb_pkg;

   // Number of synchroniser chain stages that the asynchronous request pin passes before the output register.
   localparam int unsigned SYNC_STAGES      = 3;
   // Least delay from request to grant, in peripheral clock cycles.
   localparam int unsigned MIN_GRANT_CYCLES = 3;

   // Pin widths of the external memory interface.
   localparam int unsigned ADDR_WIDTH       = 22;
   localparam int unsigned DATA_WIDTH       = 16;
   localparam int unsigned BANK_COUNT       = 4;

   // Reset values of the outputs; all strobes and selects are active low.
   localparam logic        REQ_N_RESET      = 1'b1;
   localparam logic        GRANT_N_RESET    = 1'b1;
   localparam logic        HANG_N_RESET     = 1'b1;
   localparam logic        OE_N_RESET       = 1'b0;
   localparam logic        STROBE_N_IDLE    = 1'b1;
   localparam logic        DATA_IN_RESET    = 1'b0;

   typedef enum logic [1:0] {
      EBARB_OWN     = 2'b00,
      EBARB_GRANTED = 2'b01,
      EBARB_RECLAIM = 2'b10
   } ebarb_state_t;

endpackage : ebarb_pkg

/* File: ebarb_sync.sv */
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ns
`default_nettype none

module ebarb_sync
   import ebarb_pkg::*;
#(
   parameter int unsigned STAGES    = SYNC_STAGES,
   parameter logic        RESET_VAL = 1'b1
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic asyncIn,
   output var  logic syncOut
);

   logic [STAGES-1:0] chain;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chain <= {STAGES{RESET_VAL}};
      end else begin
         chain <= {chain[STAGES-2:0], asyncIn};
      end
   end

   // Only the two last stages are compared, so the metastable first stage is never read.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         syncOut <= RESET_VAL;
      end else if (chain[STAGES-1] == chain[STAGES-2]) begin
         syncOut <= chain[STAGES-1];
      end
   end

endmodule : ebarb_sync

`default_nettype wire

/* File: ebarb_arbiter.sv */
// External bus request and grant arbiter with registered memory pin drivers.
// Notes on behaviour
// - External request has lowest priority of all.
// - Grant only with no internal request pending.
// - Grant comes at least three cycles after request.
// - Granting floats address, data, selects and strobes.
// - Grant output asserted together with released drivers.
// - Stall core accesses while bus granted away.
// - No grant between paired external read accesses.
// - Grant allowed between a read and write.
// - Exclusive option keeps interface for the core.
// - Request released: drop grant, reclaim, resume core.
// - Request handling works during boot and core reset.
// - Hang output flags access held off by grant.
`timescale 1ns/1ns
`default_nettype none

module ebarb_arbiter
   import ebarb_pkg::*;
#(
   parameter int unsigned AW    = ADDR_WIDTH,
   parameter int unsigned DW    = DATA_WIDTH,
   parameter int unsigned BANKS = BANK_COUNT
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Request pin from the outside master and the grant answer.
   input  wire logic             extBusRequest_n,
   output var  logic             extBusGrant_n,
   output var  logic             grantHangIndicator_n,
   // Configuration: core keeps the interface to itself.
   input  wire logic             coreExclusive,
   // Internal access port from the core and peripheral requesters.
   input  wire logic             accReq,
   input  wire logic             accFromCore,
   input  wire logic             accLockNext,
   input  wire logic             accDone,
   output var  logic             accGo,
   output var  logic             coreStall,
   // Memory interface values that the device drives onto its pins, and the read data it gets back.
   input  wire logic [AW-1:0]    memAddr,
   input  wire logic [DW-1:0]    memDataOut,
   input  wire logic             memDataDrive,
   input  wire logic [BANKS-1:0] memBankSel_n,
   input  wire logic             memBootSel_n,
   input  wire logic             memIoSel_n,
   input  wire logic             memRead_n,
   input  wire logic             memWrite_n,
   output var  logic [DW-1:0]    memDataIn,
   // External pins, each with an output enable that is low while driving.
   output var  logic [AW-1:0]    extAddr,
   output var  logic             extAddrOe_n,
   output var  logic [DW-1:0]    extDataOut,
   input  wire logic [DW-1:0]    extDataIn,
   output var  logic             extDataOe_n,
   output var  logic [BANKS-1:0] memoryBankSelects_n,
   output var  logic             bankSelectOe_n,
   output var  logic             bootMemorySelect_n,
   output var  logic             bootSelectOe_n,
   output var  logic             ioMemorySelect_n,
   output var  logic             ioSelectOe_n,
   output var  logic             extRead_n,
   output var  logic             extReadOe_n,
   output var  logic             extWrite_n,
   output var  logic             extWriteOe_n
);

   ebarb_state_t state;
   ebarb_state_t next_state;

   logic reqSync_n;
   logic extWants;
   logic accBusy;
   logic lockHold;
   logic startAccess;
   logic grantOk;
   logic next_owns;
   logic next_granted;
   wire logic [DW-1:0] dataSync;

   // The request pin is asynchronous; three stages settle it before arbitration,
   // which also guarantees the least request-to-grant delay.
   ebarb_sync #(
      .STAGES    (SYNC_STAGES),
      .RESET_VAL (REQ_N_RESET)
   ) u_reqSync (
      .clock   (clock),
      .rst_n   (rst_n),
      .asyncIn (extBusRequest_n),
      .syncOut (reqSync_n)
   );

   // The outside master keeps the pin low for the whole tenure; a short pulse
   // that the synchroniser filters out is never granted.
   assign extWants = !reqSync_n;

   // An internal access starts only while the device owns the bus and none is
   // in flight.
   assign startAccess = (state == EBARB_OWN) && accReq && !accBusy;

   // Internal requests always win; the external one is served only when nothing
   // internal waits, nothing is in flight and no read pair is open.
   assign grantOk = extWants
                  && !coreExclusive
                  && !accReq
                  && !accBusy
                  && !lockHold;

   always_comb begin
      next_state = state;
      unique case (state)
         EBARB_OWN: begin
            if (grantOk) begin
               next_state = EBARB_GRANTED;
            end
         end
         EBARB_GRANTED: begin
            if (!extWants) begin
               next_state = EBARB_RECLAIM;
            end
         end
         EBARB_RECLAIM: begin
            next_state = EBARB_OWN;
         end
         default: begin
            next_state = EBARB_OWN;
         end
      endcase
   end

   // Only the arbiter's own power-on reset clears this state; the core's master
   // reset and boot loading do not touch it, so requests are served throughout.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= EBARB_OWN;
      end else begin
         state <= next_state;
      end
   end

   // Drivers come back one cycle after grant drops, so the two masters never
   // drive the pins at the same time.
   assign next_owns    = (next_state == EBARB_OWN);
   assign next_granted = (next_state == EBARB_GRANTED);

   // Grant mirrors the state register exactly, so the pin never shows a grant
   // that the state machine has not taken.

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         extBusGrant_n <= GRANT_N_RESET;
      end else begin
         extBusGrant_n <= !next_granted;
      end
   end

   // An access is in flight from its start until the memory interface ends it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         accBusy <= 1'b0;
      end else if (startAccess) begin
         accBusy <= 1'b1;
      end else if (accDone) begin
         accBusy <= 1'b0;
      end
   end

   // The first read of a pair locks the bus until the second one starts. A read
   // followed by a write is not locked, so the bus may go away between them.
   // A pair whose second access never comes keeps the bus locked.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lockHold <= 1'b0;
      end else if (startAccess) begin
         lockHold <= accLockNext;
      end
   end

   // The start condition lasts one cycle only, because the access it starts
   // raises the busy flag at the same edge.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         accGo <= 1'b0;
      end else begin
         accGo <= startAccess;
      end
   end

   // Core accesses to external space stall while the bus is away; they resume
   // where they stopped once the bus is back and the access starts.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         coreStall <= 1'b0;
      end else begin
         coreStall <= accReq && accFromCore && (state != EBARB_OWN);
      end
   end

   // Hang marks an access that is ready but held off by the grant; the pin rises at
   // the edge that starts the access, or when the requester withdraws.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         grantHangIndicator_n <= HANG_N_RESET;
      end else if (startAccess || !accReq) begin
         grantHangIndicator_n <= 1'b1;
      end else if (state != EBARB_OWN) begin
         grantHangIndicator_n <= 1'b0;
      end
   end

   // Output enables of every released pin group go high at the grant edge.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         extAddrOe_n <= OE_N_RESET;
         extDataOe_n <= !OE_N_RESET;
      end else begin
         extAddrOe_n <= !next_owns;
         extDataOe_n <= !(next_owns && memDataDrive);
      end
   end

   // The select groups share one enable timing with the buses.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bankSelectOe_n <= OE_N_RESET;
         bootSelectOe_n <= OE_N_RESET;
         ioSelectOe_n   <= OE_N_RESET;
      end else begin
         bankSelectOe_n <= !next_owns;
         bootSelectOe_n <= !next_owns;
         ioSelectOe_n   <= !next_owns;
      end
   end

   // Strobe enables stay apart so each pin group can be retimed on its own.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         extReadOe_n  <= OE_N_RESET;
         extWriteOe_n <= OE_N_RESET;
      end else begin
         extReadOe_n  <= !next_owns;
         extWriteOe_n <= !next_owns;
      end
   end

   // Address and data hold their last value while released; the enables alone
   // decide who drives them.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         extAddr    <= '0;
         extDataOut <= '0;
      end else if (next_owns) begin
         extAddr    <= memAddr;
         extDataOut <= memDataOut;
      end
   end

   // Selects rest inactive while released, so a late reclaim never flashes a
   // stale select.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         memoryBankSelects_n <= {BANKS{STROBE_N_IDLE}};
         bootMemorySelect_n  <= STROBE_N_IDLE;
         ioMemorySelect_n    <= STROBE_N_IDLE;
      end else if (next_owns) begin
         memoryBankSelects_n <= memBankSel_n;
         bootMemorySelect_n  <= memBootSel_n;
         ioMemorySelect_n    <= memIoSel_n;
      end else begin
         memoryBankSelects_n <= {BANKS{STROBE_N_IDLE}};
         bootMemorySelect_n  <= STROBE_N_IDLE;
         ioMemorySelect_n    <= STROBE_N_IDLE;
      end
   end

   // Read and write strobes idle high whenever the pins are not ours.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         extRead_n  <= STROBE_N_IDLE;
         extWrite_n <= STROBE_N_IDLE;
      end else if (next_owns) begin
         extRead_n  <= memRead_n;
         extWrite_n <= memWrite_n;
      end else begin
         extRead_n  <= STROBE_N_IDLE;
         extWrite_n <= STROBE_N_IDLE;
      end
   end

   // Read data passes the same settling chain as the request, one chain a bit;
   // the extra latency is the price of never handing on a half-settled bus.
   for (genvar gi = 0; gi < DW; gi++) begin : g_dataSync
      ebarb_sync #(
         .STAGES    (SYNC_STAGES),
         .RESET_VAL (DATA_IN_RESET)
      ) u_dataSync (
         .clock   (clock),
         .rst_n   (rst_n),
         .asyncIn (extDataIn[gi]),
         .syncOut (dataSync[gi])
      );
   end

   assign memDataIn = dataSync;

endmodule : ebarb_arbiter

`default_nettype wire

/* File: ebarb_arbiter_monitor.sv */
// Concurrent checks on the ports of the external bus arbiter.
`timescale 1ns/1ns
`default_nettype none

module ebarb_arbiter_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic extBusRequest_n,
   input wire logic extBusGrant_n,
   input wire logic grantHangIndicator_n,
   input wire logic coreExclusive,
   input wire logic accReq,
   input wire logic accFromCore,
   input wire logic accLockNext,
   input wire logic accGo,
   input wire logic coreStall,
   input wire logic extAddrOe_n,
   input wire logic extDataOe_n,
   input wire logic bankSelectOe_n,
   input wire logic bootSelectOe_n,
   input wire logic ioSelectOe_n,
   input wire logic extReadOe_n,
   input wire logic extWriteOe_n
);
   logic lockHeld;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Open first half of a read pair; a grant here would split the pair.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lockHeld <= 1'b0;
      end else if (accGo) begin
         lockHeld <= accLockNext;
      end
   end

   a_grant_delay:
      assert property ($fell(extBusGrant_n) |-> !$past(extBusRequest_n, 3))
      else $error("grant came too soon after request");
   a_internal_first:
      assert property (accReq && extBusGrant_n |=> extBusGrant_n)
      else $error("grant given over internal request");
   a_drivers_float:
      assert property (!extBusGrant_n |-> &{extAddrOe_n, extDataOe_n, bankSelectOe_n,
         bootSelectOe_n, ioSelectOe_n, extReadOe_n, extWriteOe_n})
      else $error("driver enabled while granted");
   a_core_stall:
      assert property (!extBusGrant_n && accReq && accFromCore |=> coreStall)
      else $error("core not stalled while granted");
   a_pair_locked:
      assert property (lockHeld |-> extBusGrant_n)
      else $error("grant inside a read pair");
   a_exclusive_hold:
      assert property (coreExclusive && extBusGrant_n |=> extBusGrant_n)
      else $error("grant in exclusive mode");
   a_grant_return:
      assert property (extBusRequest_n [*6] |=> extBusGrant_n)
      else $error("grant kept after request release");
   a_hang_flag:
      assert property (!extBusGrant_n && accReq |=> !grantHangIndicator_n)
      else $error("held-off access not flagged");
   a_hang_clear:
      assert property (accGo |-> grantHangIndicator_n)
      else $error("hang flag left on at access start");
   a_go_owned:
      assert property (accGo |-> extBusGrant_n && !extAddrOe_n)
      else $error("access started without the bus");
endmodule : ebarb_arbiter_monitor

bind ebarb_arbiter ebarb_arbiter_monitor u_monitor (
   .clock, .rst_n, .extBusRequest_n, .extBusGrant_n, .grantHangIndicator_n, .coreExclusive,
   .accReq, .accFromCore, .accLockNext, .accGo, .coreStall, .extAddrOe_n, .extDataOe_n,
   .bankSelectOe_n, .bootSelectOe_n, .ioSelectOe_n, .extReadOe_n, .extWriteOe_n
);
`default_nettype wire

/* File: ebarb_ext_master.sv */
// Behavioural model of the outside bus master.
`timescale 1ns/1ns
`default_nettype none

module ebarb_ext_master
   import ebarb_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  want,
   input  wire logic                  extBusGrant_n,
   output var  logic                  extBusRequest_n = 1'b1,
   output var  logic [DATA_WIDTH-1:0] extDataIn = 16'h0
);
   // Data lines toggle when not ours, so a stale value never looks valid.
   // Pins move just after the rising edge, clear of the bench's stimulus.
   always @(posedge clock) begin
      extBusRequest_n <= !want;
      extDataIn <= extBusGrant_n ? ~extDataIn : 16'hc3a5;
   end
endmodule : ebarb_ext_master
`default_nettype wire

/* File: ebarb_arbiter_bench.sv */
// Self-checking bench for the external bus arbiter.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR %0t got %h exp %h", $time, a, b); end end
`define WAITF(c) begin n = 0; while (!(c) && n < 60) begin @(negedge clock); n++; end \
   if (n >= 60) begin mismatches++; tally_and_finish(); end end

module ebarb_arbiter_bench
   import ebarb_pkg::*;
;
   logic                  clock = 1'b0, rst_n = 1'b0, want = 1'b0, coreExclusive = 1'b0;
   logic                  accReq = 1'b0, accFromCore = 1'b1, accLockNext = 1'b0, accDone = 1'b0;
   logic                  memDataDrive = 1'b1, memBootSel_n = 1'b1, memIoSel_n = 1'b0;
   logic                  memRead_n = 1'b0, memWrite_n = 1'b1;
   logic [ADDR_WIDTH-1:0] memAddr = 22'h2a5c3e;
   logic [DATA_WIDTH-1:0] memDataOut = 16'h5aa5;
   logic [BANK_COUNT-1:0] memBankSel_n = 4'hb;
   wire logic             extBusRequest_n, extBusGrant_n, grantHangIndicator_n, accGo, coreStall;
   wire logic             extAddrOe_n, extDataOe_n, bankSelectOe_n, bootSelectOe_n, ioSelectOe_n;
   wire logic             extReadOe_n, extWriteOe_n, bootMemorySelect_n, ioMemorySelect_n;
   wire logic             extRead_n, extWrite_n;
   wire logic [3:0]       memoryBankSelects_n;
   wire logic [ADDR_WIDTH-1:0] extAddr;
   wire logic [DATA_WIDTH-1:0] extDataIn, memDataIn, extDataOut;
   wire logic [7:0]       strobeAll;
   wire logic [6:0]       oeAll;
   int                    tests_run = 0, mismatches = 0;

   assign oeAll = {extAddrOe_n, extDataOe_n, bankSelectOe_n, bootSelectOe_n, ioSelectOe_n,
                   extReadOe_n, extWriteOe_n};
   assign strobeAll = {memoryBankSelects_n, bootMemorySelect_n, ioMemorySelect_n, extRead_n,
                       extWrite_n};

   always #5 clock = ~clock;

   ebarb_ext_master master (.clock, .want, .extBusGrant_n, .extBusRequest_n, .extDataIn);

   ebarb_arbiter dut (
      .clock, .rst_n, .extBusRequest_n, .extBusGrant_n, .grantHangIndicator_n, .coreExclusive,
      .accReq, .accFromCore, .accLockNext, .accDone, .accGo, .coreStall, .memAddr, .memDataOut,
      .memDataDrive, .memBankSel_n, .memBootSel_n, .memIoSel_n, .memRead_n, .memWrite_n,
      .memDataIn, .extAddr, .extAddrOe_n, .extDataOut, .extDataIn, .extDataOe_n,
      .memoryBankSelects_n, .bankSelectOe_n, .bootMemorySelect_n, .bootSelectOe_n,
      .ioMemorySelect_n, .ioSelectOe_n, .extRead_n, .extReadOe_n, .extWrite_n, .extWriteOe_n);

   task automatic tally_and_finish;
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic pulse_done;
      accDone = 1'b1;
      @(negedge clock);
      accDone = 1'b0;
      @(negedge clock);
   endtask : pulse_done

   task automatic release_bus;
      int n;
      want = 1'b0;
      `WAITF(extBusGrant_n === 1'b1)
      repeat (2) @(negedge clock);
   endtask : release_bus

   task automatic t_grant;
      int n;
      want = 1'b1;
      `WAITF(extBusGrant_n === 1'b0)
      `CHK(n >= 3, 1'b1)
      `CHK(oeAll, 7'h7f)
      `CHK(strobeAll, 8'hff)
      release_bus();
      `CHK(oeAll, 7'h00)
      memAddr = 22'h15a3c1;
      memBankSel_n = 4'h4;
      {memBootSel_n, memIoSel_n, memRead_n, memWrite_n} = 4'h6;
      repeat (2) @(negedge clock);
      `CHK(extAddr, 22'h15a3c1)
      `CHK(strobeAll, 8'h46)
      `CHK(extDataOut, 16'h5aa5)
   endtask : t_grant

   task automatic t_held_off;
      int n;
      want = 1'b1;
      `WAITF(extBusGrant_n === 1'b0)
      accReq = 1'b1;
      repeat (2) @(negedge clock);
      `CHK({grantHangIndicator_n, coreStall, accGo}, 3'b010)
      want = 1'b0;
      `WAITF(accGo === 1'b1)
      accReq = 1'b0;
      `CHK(grantHangIndicator_n, 1'b1)
      `CHK(memDataIn, 16'hc3a5)
      pulse_done();
      `CHK(coreStall, 1'b0)
   endtask : t_held_off

   task automatic t_priority;
      int n;
      accFromCore = 1'b0;
      want = 1'b1;
      accReq = 1'b1;
      `WAITF(accGo === 1'b1)
      accReq = 1'b0;
      repeat (8) @(negedge clock);
      `CHK(extBusGrant_n, 1'b1)
      pulse_done();
      `WAITF(extBusGrant_n === 1'b0)
      release_bus();
   endtask : t_priority

   task automatic t_lock;
      int n;
      accReq = 1'b1;
      accLockNext = 1'b1;
      `WAITF(accGo === 1'b1)
      accReq = 1'b0;
      want = 1'b1;
      pulse_done();
      repeat (10) @(negedge clock);
      `CHK(extBusGrant_n, 1'b1)
      accReq = 1'b1;
      accLockNext = 1'b0;
      `WAITF(accGo === 1'b1)
      accReq = 1'b0;
      pulse_done();
      `WAITF(extBusGrant_n === 1'b0)
      release_bus();
   endtask : t_lock

   task automatic t_exclusive;
      int n;
      coreExclusive = 1'b1;
      want = 1'b1;
      repeat (20) @(negedge clock);
      `CHK(extBusGrant_n, 1'b1)
      coreExclusive = 1'b0;
      `WAITF(extBusGrant_n === 1'b0)
      release_bus();
   endtask : t_exclusive

   initial begin
      repeat (12) @(negedge clock);
      `CHK({extBusGrant_n, grantHangIndicator_n, accGo, coreStall, oeAll}, 11'h620)
      `CHK(strobeAll, 8'hff)
      rst_n = 1'b1;
      repeat (2) @(negedge clock);
      t_grant();
      t_held_off();
      t_priority();
      t_lock();
      t_exclusive();
      tally_and_finish();
   end
endmodule : ebarb_arbiter_bench
`default_nettype wire
